/* hw/ocfsc_params.svh */
// Register offsets, field positions, reset values and encodings for the compare unit
`ifndef OCFSC_PARAMS_SVH
`define OCFSC_PARAMS_SVH

// Register word addresses
`define OCFSC_A_CON2 4'h0
`define OCFSC_A_CTRL 4'h1
`define OCFSC_A_STAT 4'h2
`define OCFSC_A_DUTY_LO 4'h3
`define OCFSC_A_DUTY_HI 4'h4
`define OCFSC_A_PER_LO 4'h5
`define OCFSC_A_PER_HI 4'h6
`define OCFSC_A_COUNT_LO 4'h7
`define OCFSC_A_COUNT_HI 4'h8

// Second control register fields
`define OCFSC_B_FAULT_HOLD 15
`define OCFSC_B_FAULT_LEVEL 14
`define OCFSC_B_FAULT_FLOAT 13
`define OCFSC_B_INVERT 12
`define OCFSC_B_CASCADE 8
`define OCFSC_B_TRIG_SEL 7
`define OCFSC_B_TRIG_FLAG 6
`define OCFSC_B_OUT_FLOAT 5
`define OCFSC_CON2_RST 16'h000c
`define OCFSC_CON2_WMASK 16'hf1bf

// Control and status fields
`define OCFSC_B_RUN 0
`define OCFSC_B_FAULT_EN 1
`define OCFSC_B_FAULT_FLAG 0

// Source select codes
`define OCFSC_SEL_NONE 5'h00
`define OCFSC_SEL_SEQ 5'h0a

`endif

/* hw/ocfsc_pkg.sv */
// Types shared by the compare unit files
package ocfsc_pkg;
    typedef enum logic [1:0] {
        TS_OFF,
        TS_HELD,
        TS_RUN
    } ocfsc_tstate_t;
endpackage

/* hw/ocfsc_fault.sv */
// Fault flag keeper with hold or auto-exit release
`timescale 1ns/10ps
module ocfsc_fault (
    input wire logic clk,
    input wire logic nrst,
    input wire logic fault_in,
    input wire logic fault_en,
    input wire logic hold_mode,
    input wire logic sw_clear,
    output logic fault_flag,
    output logic restart
);
    logic flag_q;
    logic flag_d;
    logic set_ev;

    assign set_ev = fault_in && fault_en;

    // Set wins over any release in the same cycle
    always_comb begin
        flag_d = flag_q;
        if (set_ev) begin
            flag_d = 1'b1;
        end else if (flag_q && hold_mode) begin
            flag_d = !sw_clear;
        end else if (flag_q) begin
            flag_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign fault_flag = flag_q;
    // Falling flag starts a fresh period
    assign restart = flag_q && !flag_d;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_fault_sets: assert property (set_ev |=> flag_q)
        else $error("fault flag not set by enabled fault");
    a_hold_keeps: assert property (flag_q && hold_mode && !sw_clear |=> flag_q)
        else $error("held fault released without software clear");
    a_auto_exit: assert property (flag_q && !hold_mode && !set_ev |=> !flag_q)
        else $error("auto mode fault did not exit");
endmodule

/* hw/ocfsc_top.sv */
// Output compare unit with fault, invert, cascade and trigger/sync control
// Operation
// - Hold mode keeps fault until software clears
// - Fault drives output at fault level bit
// - Fault float enable floats pin in fault
// - Invert bit inverts compare output
// - Cascade enable makes a 32-bit compare
// - Trigger mode holds timer until source event
// - Sync mode restarts timer on source event
// - Triggered flag set by hardware on a source event in trigger mode while on
// - Output float bit releases the pin
// - Switching unit off pulses trigger out
// - One sequencer output per unit, by index
// - Select field bits 4:0, reset 0x000c
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "ocfsc_params.svh"
module ocfsc_top #(
    parameter logic [1:0] UNIT_INDEX = 2'h0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic [31:0] src_event,
    input wire logic [3:0] seq_trig,
    input wire logic fault_in,
    output logic cmp_out,
    output logic cmp_oe,
    output logic trig_out
);
    logic [15:0] con2_q;
    logic [1:0] ctrl_q;
    logic [15:0] duty_lo_q;
    logic [15:0] duty_hi_q;
    logic [15:0] per_lo_q;
    logic [15:0] per_hi_q;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic trig_flag_q;
    logic [15:0] rdata_q;
    logic cmp_out_q;
    logic cmp_oe_q;
    logic trig_out_q;
    logic run_n;
    logic ev;
    logic trig_mode;
    logic cascade;
    logic fault_flag;
    logic fault_restart;
    logic [31:0] duty;
    logic [31:0] period;
    logic period_end;
    logic raw;
    logic wr_con2;
    logic wr_ctrl;
    ocfsc_pkg::ocfsc_tstate_t tstate;

    // Pick the event source; the sequencer code maps to this unit's own output
    function automatic logic src_pick(input logic [4:0] sel, input logic [31:0] srcs,
                                      input logic [3:0] seq);
        logic r;
        r = 1'b0;
        if (sel == `OCFSC_SEL_SEQ) begin
            r = seq[UNIT_INDEX];
        end else if (sel != `OCFSC_SEL_NONE) begin
            r = srcs[sel];
        end
        return r;
    endfunction

    // Address match used by the register writes; reads decode addr in their own case
    function automatic logic hit(input logic [3:0] a, input logic [3:0] want);
        return a == want;
    endfunction

    assign wr_con2 = wr && hit(addr, `OCFSC_A_CON2);
    assign wr_ctrl = wr && hit(addr, `OCFSC_A_CTRL);
    // Self-selection is software's to avoid; the mux does not guard it
    assign ev = src_pick(con2_q[4:0], src_event, seq_trig);
    assign trig_mode = con2_q[`OCFSC_B_TRIG_SEL];
    assign cascade = con2_q[`OCFSC_B_CASCADE];
    assign run_n = wr_ctrl ? wdata[`OCFSC_B_RUN] : ctrl_q[`OCFSC_B_RUN];

    // Upper halves only count when cascaded
    assign duty = cascade ? {duty_hi_q, duty_lo_q} : {16'h0000, duty_lo_q};
    assign period = cascade ? {per_hi_q, per_lo_q} : {16'h0000, per_lo_q};
    // At or past the period, so a period lowered below the count still wraps
    assign period_end = (cnt_q >= period);
    assign raw = (tstate == ocfsc_pkg::TS_RUN) && (cnt_q < duty);

    // Timer state from enable and trigger status
    always_comb begin
        if (!ctrl_q[`OCFSC_B_RUN]) begin
            tstate = ocfsc_pkg::TS_OFF;
        end else if (trig_mode && !trig_flag_q) begin
            tstate = ocfsc_pkg::TS_HELD;
        end else begin
            tstate = ocfsc_pkg::TS_RUN;
        end
    end

    ocfsc_fault u_fault (
        .clk(clk),
        .nrst(nrst),
        .fault_in(fault_in),
        .fault_en(ctrl_q[`OCFSC_B_FAULT_EN]),
        .hold_mode(con2_q[`OCFSC_B_FAULT_HOLD]),
        .sw_clear(wr && hit(addr, `OCFSC_A_STAT) && wdata[`OCFSC_B_FAULT_FLAG]),
        .fault_flag(fault_flag),
        .restart(fault_restart)
    );

    // Second control register; status bit handled apart
    always_ff @(posedge clk) begin
        if (!nrst) begin
            con2_q <= `OCFSC_CON2_RST;
        end else if (wr_con2) begin
            con2_q <= wdata & `OCFSC_CON2_WMASK;
        end
    end

    // Run and fault enable
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_q <= 2'h0;
        end else if (wr_ctrl) begin
            ctrl_q <= wdata[1:0];
        end
    end

    // Compare and period words
    always_ff @(posedge clk) begin
        if (!nrst) begin
            duty_lo_q <= 16'h0000;
            duty_hi_q <= 16'h0000;
            per_lo_q <= 16'hffff;
            per_hi_q <= 16'hffff;
        end else if (wr) begin
            if (hit(addr, `OCFSC_A_DUTY_LO)) begin
                duty_lo_q <= wdata;
            end
            if (hit(addr, `OCFSC_A_DUTY_HI)) begin
                duty_hi_q <= wdata;
            end
            if (hit(addr, `OCFSC_A_PER_LO)) begin
                per_lo_q <= wdata;
            end
            if (hit(addr, `OCFSC_A_PER_HI)) begin
                per_hi_q <= wdata;
            end
        end
    end

    // Trigger status: hardware set beats a software write; dropped when off
    always_ff @(posedge clk) begin
        if (!nrst) begin
            trig_flag_q <= 1'b0;
        end else if (ctrl_q[`OCFSC_B_RUN] && trig_mode && ev) begin
            trig_flag_q <= 1'b1;
        end else if (!ctrl_q[`OCFSC_B_RUN]) begin
            trig_flag_q <= 1'b0;
        end else if (wr_con2) begin
            trig_flag_q <= wdata[`OCFSC_B_TRIG_FLAG];
        end
    end

    // Timer next value
    always_comb begin
        cnt_d = cnt_q;
        case (tstate)
            ocfsc_pkg::TS_OFF: begin
                cnt_d = 32'h0;
            end
            ocfsc_pkg::TS_HELD: begin
                cnt_d = 32'h0;
            end
            ocfsc_pkg::TS_RUN: begin
                if (fault_restart || period_end) begin
                    cnt_d = 32'h0;
                end else if (!trig_mode && ev) begin
                    cnt_d = 32'h0;
                end else begin
                    cnt_d = cnt_q + 32'h1;
                end
            end
            default: begin
                cnt_d = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Pin level: fault level overrides the inverted compare result
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cmp_out_q <= 1'b0;
        end else if (fault_flag) begin
            cmp_out_q <= con2_q[`OCFSC_B_FAULT_LEVEL];
        end else begin
            cmp_out_q <= raw ^ con2_q[`OCFSC_B_INVERT];
        end
    end

    // Pin drive enable
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cmp_oe_q <= 1'b0;
        end else begin
            cmp_oe_q <= !con2_q[`OCFSC_B_OUT_FLOAT]
                && !(fault_flag && con2_q[`OCFSC_B_FAULT_FLOAT]);
        end
    end

    // Trigger out to peers: period end, and one pulse when switched off
    always_ff @(posedge clk) begin
        if (!nrst) begin
            trig_out_q <= 1'b0;
        end else begin
            trig_out_q <= (ctrl_q[`OCFSC_B_RUN] && !run_n)
                || (tstate == ocfsc_pkg::TS_RUN && period_end);
        end
    end

    // Read data, valid the cycle after the strobe only
    always_ff @(posedge clk) begin
        if (!nrst || !rd) begin
            rdata_q <= 16'h0000;
        end else begin
            case (addr)
                `OCFSC_A_CON2: begin
                    rdata_q <= {con2_q[15:7], trig_flag_q, con2_q[5:0]};
                end
                `OCFSC_A_CTRL: begin
                    rdata_q <= {14'h0000, ctrl_q};
                end
                `OCFSC_A_STAT: begin
                    rdata_q <= {15'h0000, fault_flag};
                end
                `OCFSC_A_DUTY_LO: begin
                    rdata_q <= duty_lo_q;
                end
                `OCFSC_A_DUTY_HI: begin
                    rdata_q <= duty_hi_q;
                end
                `OCFSC_A_PER_LO: begin
                    rdata_q <= per_lo_q;
                end
                `OCFSC_A_PER_HI: begin
                    rdata_q <= per_hi_q;
                end
                `OCFSC_A_COUNT_LO: begin
                    rdata_q <= cnt_q[15:0];
                end
                `OCFSC_A_COUNT_HI: begin
                    rdata_q <= cnt_q[31:16];
                end
                default: begin
                    rdata_q <= 16'h0000;
                end
            endcase
        end
    end

    assign rdata = rdata_q;
    assign cmp_out = cmp_out_q;
    assign cmp_oe = cmp_oe_q;
    assign trig_out = trig_out_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_held_zero: assert property (tstate == ocfsc_pkg::TS_HELD |=> cnt_q == 32'h0)
        else $error("held timer not at zero");
    a_trig_start: assert property (ctrl_q[0] && trig_mode && ev && !wr_ctrl
        |=> trig_flag_q ##1 (tstate != ocfsc_pkg::TS_HELD))
        else $error("trigger event did not start timer");
    a_sync_restart: assert property (tstate == ocfsc_pkg::TS_RUN && !trig_mode && ev
        |=> cnt_q == 32'h0)
        else $error("sync event did not restart timer");
    a_off_pulse: assert property (ctrl_q[0] && wr_ctrl && !wdata[0] |=> trig_out_q)
        else $error("no trigger out when switched off");
    a_fault_level: assert property (fault_flag |=> cmp_out_q == $past(con2_q[14]))
        else $error("fault level not driven");
    a_fault_float: assert property (fault_flag && con2_q[13] |=> !cmp_oe_q)
        else $error("pin driven in floating fault");
    a_out_float: assert property (con2_q[5] |=> !cmp_oe_q)
        else $error("pin driven while floated");
    a_invert_out: assert property (!fault_flag |=> cmp_out_q == ($past(raw) ^ $past(con2_q[12])))
        else $error("output polarity wrong");
    a_narrow_count: assert property (!cascade && !$past(cascade) |-> cnt_q[31:16] == 16'h0000)
        else $error("16-bit timer overflowed into upper half");
    a_reset_value: assert property ($past(!nrst) |-> con2_q == 16'h000c)
        else $error("control register reset value wrong");
endmodule

/* verif/ocfsc_far_model.sv */
// Far-side model: timer sources, sequencer outputs and the fault input
`timescale 1ns/10ps
module ocfsc_far_model (
    input wire logic clk,
    output logic [31:0] src_event,
    output logic [3:0] seq_trig,
    output logic fault_in
);
    // Quiet at time zero so no stray event reaches the unit
    initial begin
        {src_event, seq_trig, fault_in} = 37'h0;
    end
    // One-cycle event on a numbered source, launched just after an edge
    task automatic pulse_src(input logic [4:0] idx);
        @(posedge clk);
        src_event <= 32'h0000_0001 << idx;
        @(posedge clk);
        src_event <= 32'h0000_0000;
    endtask
    // One-cycle pulse on one sequencer output only
    task automatic pulse_seq(input logic [1:0] idx);
        @(posedge clk);
        seq_trig <= 4'h1 << idx;
        @(posedge clk);
        seq_trig <= 4'h0;
    endtask
    // Fault is a level, held until changed
    task automatic set_fault(input logic v);
        @(posedge clk);
        fault_in <= v;
    endtask
endmodule

/* verif/ocfsc_top_tb.sv */
// Self-checking bench for the compare unit fault, trigger and sync control
`timescale 1ns/10ps
`include "ocfsc_params.svh"
module ocfsc_top_tb;
    logic clk, nrst, wr, rd, fault_in, cmp_out, cmp_oe, trig_out;
    logic [3:0] addr, seq_trig;
    logic [15:0] wdata, rdata, v;
    logic [31:0] src_event;
    logic seen;
    int fail_count = 0;
    int total_checks = 0;
    // Unit 2 so the sequencer lookup is not the trivial index
    ocfsc_top #(.UNIT_INDEX(2'h2)) DUT (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .src_event(src_event), .seq_trig(seq_trig), .fault_in(fault_in), .cmp_out(cmp_out),
        .cmp_oe(cmp_oe), .trig_out(trig_out));
    ocfsc_far_model far (.clk(clk), .src_event(src_event), .seq_trig(seq_trig), .fault_in(fault_in));
    // 25 ns clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic end_sim();
        if (fail_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        rd_reg(a);
        chk(v, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Hang guard, well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_sim();
    end
    initial begin
        nrst = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rchk(`OCFSC_A_CON2, 16'h000c);
        chk({15'h0, cmp_oe}, 16'h0001);
        rchk(4'hf, 16'h0000);
        wr_reg(`OCFSC_A_CON2, 16'hffa3);
        rchk(`OCFSC_A_CON2, 16'hf1a3);
        cyc(2);
        chk({15'h0, cmp_oe}, 16'h0000);
        // Duty 0 keeps the plain output low, so only inversion lifts it
        wr_reg(`OCFSC_A_PER_LO, 16'h0007);
        wr_reg(`OCFSC_A_CTRL, 16'h0003);
        for (int i = 0; i < 2; i++) begin
            wr_reg(`OCFSC_A_CON2, {3'b000, i[0], 12'h000});
            cyc(4);
            chk({15'h0, cmp_out}, {15'h0, i[0]});
        end
        // Each level and float pairing; invert opposes level so the fault shows
        for (int i = 0; i < 4; i++) begin
            wr_reg(`OCFSC_A_CON2, {1'b0, i[0], i[1], ~i[0], 12'h000});
            far.set_fault(1'b1);
            cyc(4);
            if (!i[1]) chk({15'h0, cmp_out}, {15'h0, i[0]});
            chk({15'h0, cmp_oe}, {15'h0, ~i[1]});
            rchk(`OCFSC_A_STAT, 16'h0001);
            far.set_fault(1'b0);
            cyc(3);
            rchk(`OCFSC_A_STAT, 16'h0000);
        end
        // Hold mode keeps the flag until software clears it
        wr_reg(`OCFSC_A_CON2, 16'h8000);
        far.set_fault(1'b1);
        cyc(3);
        far.set_fault(1'b0);
        cyc(3);
        rchk(`OCFSC_A_STAT, 16'h0001);
        wr_reg(`OCFSC_A_STAT, 16'h0001);
        rchk(`OCFSC_A_STAT, 16'h0000);
        // Low period 3 with a nonzero high word: wraps only when not cascaded
        wr_reg(`OCFSC_A_PER_LO, 16'h0003);
        wr_reg(`OCFSC_A_PER_HI, 16'h0001);
        cyc(10);
        rd_reg(`OCFSC_A_COUNT_LO);
        chk({15'h0, v <= 16'h0003}, 16'h0001);
        wr_reg(`OCFSC_A_CON2, 16'h0100);
        cyc(8);
        rd_reg(`OCFSC_A_COUNT_LO);
        chk({15'h0, v > 16'h0003}, 16'h0001);
        // Stopping the unit sends a trigger-out pulse
        wr_reg(`OCFSC_A_CTRL, 16'h0002);
        // Pulse stands one cycle only, so look from the write's own edge on
        seen = 1'b0;
        repeat (3) begin
            #1 seen = seen | trig_out;
            @(posedge clk);
        end
        chk({15'h0, seen}, 16'h0001);
        // Triggered mode on source 1, never this unit itself
        wr_reg(`OCFSC_A_PER_LO, 16'h0100);
        wr_reg(`OCFSC_A_PER_HI, 16'h0000);
        wr_reg(`OCFSC_A_CON2, 16'h0081);
        wr_reg(`OCFSC_A_CTRL, 16'h0003);
        cyc(3);
        rchk(`OCFSC_A_CON2, 16'h0081);
        rchk(`OCFSC_A_COUNT_LO, 16'h0000);
        far.pulse_src(5'h01);
        cyc(1);
        rchk(`OCFSC_A_CON2, 16'h00c1);
        cyc(2);
        rd_reg(`OCFSC_A_COUNT_LO);
        chk({15'h0, v != 16'h0000}, 16'h0001);
        // Source dropped first, so a stopping peer's pulse cannot trigger us
        wr_reg(`OCFSC_A_CON2, 16'h0080);
        far.pulse_src(5'h01);
        cyc(1);
        rchk(`OCFSC_A_CON2, 16'h0080);
        // Sequencer source: only this unit's own output counts
        wr_reg(`OCFSC_A_CTRL, 16'h0002);
        wr_reg(`OCFSC_A_CON2, `OCFSC_SEL_SEQ | 16'h0080);
        wr_reg(`OCFSC_A_CTRL, 16'h0003);
        far.pulse_seq(2'h1);
        cyc(2);
        rchk(`OCFSC_A_CON2, 16'h008a);
        far.pulse_seq(2'h2);
        cyc(2);
        rchk(`OCFSC_A_CON2, 16'h00ca);
        // Sync mode: an event pulls a free-running count back to zero
        wr_reg(`OCFSC_A_CTRL, 16'h0002);
        wr_reg(`OCFSC_A_CON2, 16'h0001);
        wr_reg(`OCFSC_A_DUTY_LO, 16'h0080);
        wr_reg(`OCFSC_A_CTRL, 16'h0003);
        cyc(20);
        // Count still below duty, plain polarity: the pin is high
        chk({15'h0, cmp_out}, 16'h0001);
        far.pulse_src(5'h01);
        rd_reg(`OCFSC_A_COUNT_LO);
        chk({15'h0, v < 16'h0004}, 16'h0001);
        end_sim();
    end
endmodule
